// ===== rtl/tmr_device.sv
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_device #(
    parameter int PRESCALE_W = `TMR_DIV1024_BITS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    tmr_if.dev               bus,
    input  wire logic        capture_pin,
    input  wire logic        comparator_output,
    input  wire logic        external_tick_pin,
    output tmr_pkg::tmr_word_t counter_value,
    output logic             count_top,
    output logic             count_floor,
    output logic             count_down,
    output logic             match_block
);
    logic [1:0]            wgm_lo;
    logic [1:0]            wgm_hi;
    logic [2:0]            tick_source_select;
    logic                  capture_filter_enable;
    logic                  capture_edge_rising;
    logic                  comparator_capture_select;
    logic                  overflow_flag;
    logic                  capture_flag;
    logic                  overflow_irq_enable;
    logic                  capture_irq_enable;
    logic [7:0]            temp_byte;
    tmr_pkg::tmr_word_t    capture_register;
    logic [PRESCALE_W-1:0] prescale;
    logic                  ext_s1;
    logic                  ext_s2;
    logic                  ext_prev;
    logic                  timer_tick;
    logic [3:0]            waveform_mode_field;
    tmr_pkg::tmr_word_t    top;
    tmr_pkg::tmr_word_t    next_count;
    logic                  next_down;
    logic                  overflow_hit;
    logic                  pin_level;
    logic                  cmp_level;
    logic                  src_level;
    logic                  src_prev;
    logic                  input_active;
    logic                  capture_event;
    logic                  count_wr;
    logic                  cap_wr;
    logic                  flags_wr;

    // Mode bits live in both control registers
    assign waveform_mode_field = {wgm_hi, wgm_lo};

    // Modes that take the ceiling from the capture register
    function automatic logic icr_top(input logic [3:0] m);
        icr_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
    endfunction : icr_top

    // Dual-slope modes count up then down
    function automatic logic dual_slope(input logic [3:0] m);
        dual_slope = (m != 4'h0) && (m <= 4'hB) && (m != 4'h4) && (m < 4'h5 || m > 4'h7);
    endfunction : dual_slope

    // Decoded bus strobes
    assign count_wr = bus.io_wr && (bus.io_addr == `TMR_A_COUNT_LO);
    assign cap_wr   = bus.io_wr && (bus.io_addr == `TMR_A_CAP_LO)
                      && icr_top(waveform_mode_field);
    assign flags_wr = bus.io_wr && (bus.io_addr == `TMR_A_FLAGS);

    // Ceiling per mode; OCR-based modes have no OCR here, so they run to MAX
    always_comb
    begin
        unique case (waveform_mode_field)
            4'h1, 4'h5: top = `TMR_TOP8;
            4'h2, 4'h6: top = `TMR_TOP9;
            4'h3, 4'h7: top = `TMR_TOP10;
            4'h8, 4'hA, 4'hC, 4'hE: top = capture_register;
            default: top = `TMR_MAX;
        endcase
    end

    // External tick pin is synchronised before edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_s1   <= 1'b0;
            ext_s2   <= 1'b0;
            ext_prev <= 1'b0;
            prescale <= '0;
        end
        else
        begin
            ext_s1   <= external_tick_pin;
            ext_s2   <= ext_s1;
            ext_prev <= ext_s2;
            prescale <= prescale + 1'b1;
        end
    end

    // Tick selection; zero selects nothing and the counter halts
    always_comb
    begin
        unique case (tick_source_select)
            3'h0: timer_tick = 1'b0;
            3'h1: timer_tick = 1'b1;
            3'h2: timer_tick = &prescale[`TMR_DIV8_BITS-1:0];
            3'h3: timer_tick = &prescale[`TMR_DIV64_BITS-1:0];
            3'h4: timer_tick = &prescale[`TMR_DIV256_BITS-1:0];
            3'h5: timer_tick = &prescale[`TMR_DIV1024_BITS-1:0];
            3'h6: timer_tick = ext_prev && !ext_s2;
            3'h7: timer_tick = !ext_prev && ext_s2;
        endcase
    end

    // Next count and overflow point for one tick
    always_comb
    begin
        next_down    = count_down;
        next_count   = counter_value + 16'h0001;
        overflow_hit = 1'b0;
        if (dual_slope(waveform_mode_field))
        begin
            if (count_down && counter_value == 16'h0000)
            begin
                next_down = 1'b0;
            end
            else if (count_down || counter_value >= top)
            begin
                next_down  = 1'b1;
                next_count = counter_value - 16'h0001;
            end
            overflow_hit = (next_count == 16'h0000);
        end
        else if (counter_value == top)
        begin
            next_count   = 16'h0000;
            // Clear-on-capture-ceiling mode overflows only when the ceiling is MAX
            overflow_hit = (waveform_mode_field >= 4'h5 && waveform_mode_field != 4'hC)
                           || (top == `TMR_MAX);
        end
        else
        begin
            overflow_hit = (counter_value == `TMR_MAX);
        end
    end

    // Counter: a CPU write outranks any step, with or without a tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_value <= 16'h0000;
            count_down    <= 1'b0;
        end
        else if (count_wr)
        begin
            counter_value <= {temp_byte, bus.io_wdata};
        end
        else if (timer_tick)
        begin
            counter_value <= next_count;
            count_down    <= next_down;
        end
    end

    // Ceiling and floor indications track the stored count one clock later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_top   <= 1'b0;
            count_floor <= 1'b0;
        end
        else
        begin
            count_top   <= (counter_value == top);
            count_floor <= (counter_value == 16'h0000);
        end
    end

    // Compare blocking lasts through the next tick, even when stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_block <= 1'b0;
        else if (count_wr || (bus.io_wr && bus.io_addr == `TMR_A_COUNT_HI))
            match_block <= 1'b1;
        else if (timer_tick)
            match_block <= 1'b0;
    end

    // Capture inputs: pin, or the comparator; software can drive the pin
    tmr_filter u_pin_filter (
        .pclk          (pclk),
        .presetn       (presetn),
        .raw           (capture_pin),
        .filter_enable (capture_filter_enable),
        .level         (pin_level)
    );

    tmr_filter u_cmp_filter (
        .pclk          (pclk),
        .presetn       (presetn),
        .raw           (comparator_output),
        .filter_enable (capture_filter_enable),
        .level         (cmp_level)
    );

    // Switching source may look like an edge; software clears the flag after
    assign src_level     = comparator_capture_select ? cmp_level : pin_level;
    assign input_active  = !icr_top(waveform_mode_field);
    assign capture_event = input_active && (capture_edge_rising ?
                           (src_level && !src_prev) : (!src_level && src_prev));

    // Capture register: no overrun guard, newest event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_prev         <= 1'b0;
            capture_register <= 16'h0000;
        end
        else
        begin
            src_prev <= src_level;
            if (cap_wr)
                capture_register <= {temp_byte, bus.io_wdata};
            else if (capture_event)
                capture_register <= counter_value;
        end
    end

    // Flags: hardware set wins over service ack or write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_flag  <= 1'b0;
            overflow_flag <= 1'b0;
        end
        else
        begin
            if (capture_event)
                capture_flag <= 1'b1;
            else if (bus.capture_irq_ack || (flags_wr && bus.io_wdata[`TMR_B_CAP]))
                capture_flag <= 1'b0;
            if (timer_tick && !count_wr && overflow_hit)
                overflow_flag <= 1'b1;
            else if (bus.overflow_irq_ack || (flags_wr && bus.io_wdata[`TMR_B_OVF]))
                overflow_flag <= 1'b0;
        end
    end

    // Interrupt requests, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus.capture_irq  <= 1'b0;
            bus.overflow_irq <= 1'b0;
        end
        else
        begin
            bus.capture_irq  <= capture_flag && capture_irq_enable;
            bus.overflow_irq <= overflow_flag && overflow_irq_enable;
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wgm_lo                    <= 2'h0;
            wgm_hi                    <= 2'h0;
            tick_source_select        <= 3'h0;
            capture_filter_enable     <= 1'b0;
            capture_edge_rising       <= 1'b0;
            overflow_irq_enable       <= 1'b0;
            capture_irq_enable        <= 1'b0;
            comparator_capture_select <= 1'b0;
        end
        else if (bus.io_wr)
        begin
            unique case (bus.io_addr)
                `TMR_A_CTRL_A: wgm_lo <= bus.io_wdata[1:0];
                `TMR_A_CTRL_B:
                begin
                    capture_filter_enable <= bus.io_wdata[`TMR_B_FILTER];
                    capture_edge_rising   <= bus.io_wdata[`TMR_B_EDGE];
                    wgm_hi                <= bus.io_wdata[4:3];
                    tick_source_select    <= bus.io_wdata[2:0];
                end
                `TMR_A_MASK:
                begin
                    overflow_irq_enable <= bus.io_wdata[`TMR_B_OVF];
                    capture_irq_enable  <= bus.io_wdata[`TMR_B_CAP];
                end
                `TMR_A_COMP: comparator_capture_select <= bus.io_wdata[`TMR_B_CMP_SEL];
                default: ;
            endcase
        end
    end

    // Shared high-byte latch for 16-bit access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            temp_byte <= 8'h00;
        else if (bus.io_rd && bus.io_addr == `TMR_A_COUNT_LO)
            temp_byte <= counter_value[15:8];
        else if (bus.io_rd && bus.io_addr == `TMR_A_CAP_LO)
            temp_byte <= capture_register[15:8];
        else if (bus.io_wr && (bus.io_addr == `TMR_A_COUNT_HI || bus.io_addr == `TMR_A_CAP_HI))
            temp_byte <= bus.io_wdata;
    end

    // Read data and access acknowledge, one clock after the strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus.io_rdata <= 8'h00;
            bus.io_ack   <= 1'b0;
        end
        else
        begin
            bus.io_ack <= bus.io_rd || bus.io_wr;
            if (bus.io_rd)
            begin
                unique case (bus.io_addr)
                    `TMR_A_CTRL_A:   bus.io_rdata <= {6'h00, wgm_lo};
                    `TMR_A_CTRL_B:   bus.io_rdata <= {capture_filter_enable, capture_edge_rising,
                                                      1'b0, wgm_hi, tick_source_select};
                    `TMR_A_COUNT_LO: bus.io_rdata <= counter_value[7:0];
                    `TMR_A_COUNT_HI,
                    `TMR_A_CAP_HI:   bus.io_rdata <= temp_byte;
                    `TMR_A_CAP_LO:   bus.io_rdata <= capture_register[7:0];
                    `TMR_A_FLAGS:    bus.io_rdata <= {2'h0, capture_flag, 4'h0, overflow_flag};
                    `TMR_A_MASK:     bus.io_rdata <= {2'h0, capture_irq_enable, 4'h0,
                                                      overflow_irq_enable};
                    `TMR_A_COMP:     bus.io_rdata <= {5'h00, comparator_capture_select, 2'h0};
                    default:         bus.io_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule : tmr_device
`default_nettype wire

// ===== rtl/tmr_defs.svh
// Summary of operation
// - 16-bit counter clears, counts up or down
// - Flags at ceiling and zero; clear zeroes all
// - Low count read latches high byte for reading
// - High write loads latch; low write loads all
// - Tick source select; zero stops the counter
// - Counter stays accessible without any tick
// - CPU write beats a same-cycle count step
// - Four-bit waveform mode split over two registers
// - Overflow flag set per mode, requests interrupt
// - Selected edge copies counter into capture register
// - Capture flag set in the copy cycle
// - Enabled flag interrupts; cleared by service or one
// - Capture read low first, high via latch
// - Capture writable only when it sets ceiling
// - Comparator select bit switches capture source
// - Software clears capture flag after source change
// - Filter passes change only when four samples agree
// - Filter adds four system clocks, ignores prescaler
// - Capture input off when capture sets ceiling
// - Driving the pin by software captures too
// - New capture overwrites unread value
// - Duty measurement: flip edge, then clear flag
// - Count write blocks compare on next tick
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
// Device register addresses on the 8-bit I/O bus
`define TMR_A_CTRL_A     4'h0
`define TMR_A_CTRL_B     4'h1
`define TMR_A_COUNT_LO   4'h2
`define TMR_A_COUNT_HI   4'h3
`define TMR_A_CAP_LO     4'h4
`define TMR_A_CAP_HI     4'h5
`define TMR_A_FLAGS      4'h6
`define TMR_A_MASK       4'h7
`define TMR_A_COMP       4'h8
// Field positions
`define TMR_B_FILTER     7
`define TMR_B_EDGE       6
`define TMR_B_OVF        0
`define TMR_B_CAP        5
`define TMR_B_CMP_SEL    2
// Prescaler divider widths (divide by 8, 64, 256, 1024)
`define TMR_DIV8_BITS    3
`define TMR_DIV64_BITS   6
`define TMR_DIV256_BITS  8
`define TMR_DIV1024_BITS 10
// Count constants
`define TMR_MAX          16'hFFFF
`define TMR_TOP8         16'h00FF
`define TMR_TOP9         16'h01FF
`define TMR_TOP10        16'h03FF
`define TMR_FILTER_DEPTH 4
// Controller APB map
`define TMR_P_CMD        12'h000
`define TMR_P_STATUS     12'h004
`define TMR_P_ACK        12'h008
`endif

// ===== rtl/tmr_pkg.sv
package tmr_pkg;
    typedef logic [15:0] tmr_word_t;
    typedef logic [3:0]  tmr_addr_t;
    typedef enum logic [0:0] {
        TMR_HS_IDLE,
        TMR_HS_WAIT
    } tmr_host_state_t;
endpackage : tmr_pkg

// ===== rtl/tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tmr_if;
    tmr_pkg::tmr_addr_t io_addr;
    logic               io_rd;
    logic               io_wr;
    logic [7:0]         io_wdata;
    logic [7:0]         io_rdata;
    logic               io_ack;
    logic               capture_irq;
    logic               overflow_irq;
    logic               capture_irq_ack;
    logic               overflow_irq_ack;
    modport dev  (input io_addr, io_rd, io_wr, io_wdata, capture_irq_ack, overflow_irq_ack,
                  output io_rdata, io_ack, capture_irq, overflow_irq);
    modport host (output io_addr, io_rd, io_wr, io_wdata, capture_irq_ack, overflow_irq_ack,
                  input io_rdata, io_ack, capture_irq, overflow_irq);
endinterface : tmr_if
`default_nettype wire

// ===== rtl/tmr_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_filter #(
    parameter int DEPTH = `TMR_FILTER_DEPTH
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raw,
    input  wire logic filter_enable,
    output logic      level
);
    logic             sync1;
    logic             sync2;
    logic [DEPTH-1:0] pipe;

    // Two-stage synchroniser; only the second stage is read below
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    // Sample pipeline runs on pclk, untouched by the prescaler
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pipe <= '0;
        else
            pipe <= {pipe[DEPTH-2:0], sync2};
    end

    // Filtered level moves only when the whole pipe agrees, or follows sync2 when the filter is off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            level <= 1'b0;
        else if (!filter_enable)
            level <= sync2;
        else if (&pipe)
            level <= 1'b1;
        else if (~|pipe)
            level <= 1'b0;
    end
endmodule : tmr_filter
`default_nettype wire

// ===== rtl/tmr_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    tmr_if.host              bus,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    tmr_pkg::tmr_host_state_t state;
    logic [7:0]               last_rdata;
    logic                     setup;
    logic                     access_wr;

    assign setup     = psel && !penable;
    assign access_wr = psel && penable && pwrite;

    // Zero-wait slave; read data is prepared during the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (setup && !pwrite)
                prdata <= (paddr == `TMR_P_STATUS) ?
                          {16'h0000, last_rdata, 5'h00, bus.overflow_irq, bus.capture_irq,
                           state == tmr_pkg::TMR_HS_WAIT} : 32'h0000_0000;
        end
    end

    // One device access at a time; a command while busy is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state         <= tmr_pkg::TMR_HS_IDLE;
            bus.io_addr   <= 4'h0;
            bus.io_rd     <= 1'b0;
            bus.io_wr     <= 1'b0;
            bus.io_wdata  <= 8'h00;
            last_rdata    <= 8'h00;
        end
        else
        begin
            bus.io_rd <= 1'b0;
            bus.io_wr <= 1'b0;
            unique case (state)
                tmr_pkg::TMR_HS_IDLE:
                    if (access_wr && paddr == `TMR_P_CMD)
                    begin
                        bus.io_wdata <= pwdata[7:0];
                        bus.io_addr  <= pwdata[11:8];
                        bus.io_wr    <= pwdata[12];
                        bus.io_rd    <= !pwdata[12];
                        state        <= tmr_pkg::TMR_HS_WAIT;
                    end
                tmr_pkg::TMR_HS_WAIT:
                    if (bus.io_ack)
                    begin
                        last_rdata <= bus.io_rdata;
                        state      <= tmr_pkg::TMR_HS_IDLE;
                    end
            endcase
        end
    end

    // Interrupt service acknowledges as one-clock pulses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus.capture_irq_ack  <= 1'b0;
            bus.overflow_irq_ack <= 1'b0;
        end
        else
        begin
            bus.capture_irq_ack  <= access_wr && paddr == `TMR_P_ACK && pwdata[0];
            bus.overflow_irq_ack <= access_wr && paddr == `TMR_P_ACK && pwdata[1];
        end
    end
endmodule : tmr_host
`default_nettype wire

// ===== bench/tmr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       io_rd,
    input wire logic       io_wr,
    input wire logic [7:0] io_rdata,
    input wire logic       io_ack,
    input wire logic       capture_irq,
    input wire logic       overflow_irq,
    input wire logic       capture_irq_ack,
    input wire logic       overflow_irq_ack
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Each strobe is a lone pulse answered in the next cycle
    AST_ACK_NEXT: assert property ((io_rd || io_wr) |=> io_ack)
        else $error("no answer after strobe");
    AST_STROBE_PULSE: assert property ((io_rd || io_wr) |=> !io_rd && !io_wr)
        else $error("strobe longer than one cycle");
    AST_ACK_CAUSE: assert property (io_ack |-> $past(io_rd) || $past(io_wr))
        else $error("answer without strobe");
    AST_ONE_KIND: assert property (!(io_rd && io_wr))
        else $error("read and write together");
    // Read data moves only with the answer to a read
    AST_RDATA_HOLD: assert property ($changed(io_rdata) |-> io_ack && $past(io_rd))
        else $error("read data changed without read");
    // Requests drop only two clocks after service or a register write
    AST_CAP_DROP: assert property ($fell(capture_irq) |->
        $past(capture_irq_ack, 2) || $past(io_wr, 2))
        else $error("capture request dropped without cause");
    AST_OVF_DROP: assert property ($fell(overflow_irq) |->
        $past(overflow_irq_ack, 2) || $past(io_wr, 2))
        else $error("overflow request dropped without cause");
    AST_SVC_PULSE: assert property (capture_irq_ack || overflow_irq_ack |=>
        !capture_irq_ack && !overflow_irq_ack)
        else $error("service pulse too long");
    cover property (io_ack && $past(io_rd));
    cover property ($fell(capture_irq));
    cover property ($fell(overflow_irq));
endmodule : tmr_monitor
`default_nettype wire

// ===== bench/timer16_counter_and_capture_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_counter_and_capture_bench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic        pready, cap = 0, cmp = 0, ext = 0, rd_q = 0, wc_q = 0, cf, mb, ct, cd;
    logic [15:0] cv, k, exq[$];
    logic [7:0]  tmp;
    int          num_errors = 0, n_tests = 0, seed = 32'hcd0a;
    tmr_if tmr_if_i();
    tmr_device tmr_device_i (.pclk(pclk), .presetn(presetn), .bus(tmr_if_i),
        .capture_pin(cap), .comparator_output(cmp), .external_tick_pin(ext),
        .counter_value(cv), .count_top(ct), .count_floor(cf), .count_down(cd),
        .match_block(mb));
    tmr_host tmr_host_i (.pclk(pclk), .presetn(presetn), .bus(tmr_if_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr());
    tmr_monitor tmr_monitor_i (.pclk(pclk), .presetn(presetn), .io_rd(tmr_if_i.io_rd),
        .io_wr(tmr_if_i.io_wr), .io_rdata(tmr_if_i.io_rdata), .io_ack(tmr_if_i.io_ack),
        .capture_irq(tmr_if_i.capture_irq), .overflow_irq(tmr_if_i.overflow_irq),
        .capture_irq_ack(tmr_if_i.capture_irq_ack),
        .overflow_irq_ack(tmr_if_i.overflow_irq_ack));
    initial forever #12.5 pclk = ~pclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Device access through the command register, then poll until idle
    task automatic dop(input logic w, input logic [3:0] a, input logic [7:0] d);
        apb(1, 12'h000, {19'h0_0000, w, a, d});
        do apb(0, 12'h004, 32'h0000_0000); while (rv[0] !== 1'b0);
    endtask : dop
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exq.push_back({8'h00, e});
        dop(0, a, 8'h00);
    endtask : rd
    // Our own copy of the shared latch predicts a full count load
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        if (a == 4'h2)
            exq.push_back({tmp, d});
        if (a == 4'h3 || a == 4'h5)
            tmp = d;
        dop(1, a, d);
    endtask : wr
    task automatic tally_and_finish;
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // Oldest note is matched against each read answer or count load
    always @(posedge pclk)
    begin
        rd_q <= tmr_if_i.io_rd;
        wc_q <= tmr_if_i.io_wr && tmr_if_i.io_addr == 4'h2;
        if (rd_q && tmr_if_i.io_ack)
            chk({8'h00, tmr_if_i.io_rdata}, exq.pop_front());
        if (wc_q)
            chk(cv, exq.pop_front());
    end
    initial
    begin
        #200_000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        chk({15'h0000, cf}, 16'h0001);
        rd(4'h1, 8'h00);
        k = 16'($random(seed));
        wr(4'h3, k[15:8]);
        wr(4'h2, k[7:0]);
        repeat (40) @(posedge pclk);
        chk(cv, k);
        chk({15'h0000, mb}, 16'h0001);
        rd(4'h2, k[7:0]);
        rd(4'h3, k[15:8]);
        // Count on every system clock; a load while counting must win
        wr(4'h1, 8'h01);
        k = cv;
        @(posedge pclk);
        chk(cv, k + 16'h0001);
        wr(4'h3, 8'h12);
        wr(4'h2, 8'h34);
        wr(4'h3, 8'hff);
        wr(4'h2, 8'hfe);
        wr(4'h1, 8'h00);
        wr(4'h7, 8'h21);
        rd(4'h6, 8'h01);
        apb(0, 12'h004, 32'h0000_0000);
        chk({15'h0000, rv[2]}, 16'h0001);
        apb(1, 12'h008, 32'h0000_0002);
        rd(4'h6, 8'h00);
        // Bit 0 picks comparator and falling edge, bit 1 the filter
        for (int i = 0; i < 4; i++)
        begin
            cap <= i[0];
            cmp <= i[0];
            wr(4'h8, {5'h00, i[0], 2'h0});
            wr(4'h1, {i[1], !i[0], 6'h00});
            wr(4'h6, 8'h21);
            cap <= 1;
            cmp <= 0;
            repeat (2) @(posedge pclk);
            cap <= i[0];
            cmp <= i[0];
            repeat (12) @(posedge pclk);
            rd(4'h6, i[1] ? 8'h00 : 8'h20);
            k = 16'($random(seed));
            wr(4'h3, k[15:8]);
            wr(4'h2, k[7:0]);
            cap <= 1;
            cmp <= 0;
            repeat (12) @(posedge pclk);
            rd(4'h6, 8'h20);
            rd(4'h4, k[7:0]);
            rd(4'h5, k[15:8]);
            apb(0, 12'h004, 32'h0000_0000);
            chk({15'h0000, rv[1]}, 16'h0001);
            apb(1, 12'h008, 32'h0000_0001);
            rd(4'h6, 8'h00);
        end
        // Capture writes are ignored until a ceiling mode is chosen
        wr(4'h5, 8'haa);
        wr(4'h4, 8'h55);
        rd(4'h4, k[7:0]);
        wr(4'h1, 8'h18);
        wr(4'h5, 8'haa);
        wr(4'h4, 8'h55);
        // A falling edge must not capture over the ceiling
        cmp <= 1;
        repeat (6) @(posedge pclk);
        cmp <= 0;
        repeat (6) @(posedge pclk);
        rd(4'h6, 8'h00);
        rd(4'h4, 8'h55);
        rd(4'h5, 8'haa);
        wr(4'h3, 8'haa);
        wr(4'h2, 8'h55);
        chk({15'h0000, ct}, 16'h0001);
        // One rising edge on the tick pin, one step
        wr(4'h1, 8'h07);
        k = cv;
        ext <= 1;
        repeat (6) @(posedge pclk);
        ext <= 0;
        repeat (6) @(posedge pclk);
        chk(cv, k + 16'h0001);
        // Dual slope above an 8-bit ceiling turns down
        wr(4'h0, 8'h01);
        wr(4'h3, 8'h01);
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h01);
        wr(4'h1, 8'h00);
        chk({15'h0000, cd}, 16'h0001);
        tally_and_finish();
    end
endmodule : timer16_counter_and_capture_bench
`default_nettype wire
